// ===== verilog/pmu_pkg.sv
package pmu_pkg;

  // Register word offsets (byte addresses, one word each)
  localparam logic [7:0] OFF_CLKOUT_SEL = 8'h00;
  localparam logic [7:0] OFF_MAIN_SEL = 8'h04;
  localparam logic [7:0] OFF_PCLK_GATE = 8'h08;
  localparam logic [7:0] OFF_PWR_CTRL = 8'h0c;
  localparam logic [7:0] OFF_START_EN = 8'h10;
  localparam logic [7:0] OFF_START_FLAG = 8'h14;
  localparam logic [7:0] OFF_BROWN_CFG = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1c;
  localparam logic [7:0] OFF_RESET_SRC = 8'h20;

  // Field positions
  localparam int PWR_SLEEP_BIT = 0;
  localparam int PWR_DEEP_BIT = 1;
  localparam int PWR_DPD_BIT = 2;
  localparam int PWR_KEEP_WDOSC_BIT = 3;
  localparam int PWR_KEEP_BROWN_BIT = 4;

  // Reset values
  localparam logic [1:0] CLKOUT_SEL_RST = 2'h0;
  localparam logic [1:0] MAIN_SEL_RST = 2'h0;
  localparam logic [15:0] PCLK_GATE_RST = 16'hffff;
  localparam logic [12:0] START_EN_RST = 13'h0000;
  localparam logic [3:0] BROWN_CFG_RST = 4'h0;

  // Clock source codes; code 0 is the internal RC oscillator
  localparam logic [1:0] SRC_IRC = 2'h0;
  localparam logic [1:0] SRC_SYSOSC = 2'h1;
  localparam logic [1:0] SRC_WDOSC = 2'h2;
  localparam logic [1:0] SRC_MAIN = 2'h3;

  // Flash protection patterns
  localparam logic [31:0] PAT_LEVEL1 = 32'h12345678;
  localparam logic [31:0] PAT_LEVEL2 = 32'h87654321;
  localparam logic [31:0] PAT_LEVEL3 = 32'h43218765;

  // Timing: flash pattern load after reset
  localparam int IRC_MHZ = 12;
  localparam int FLASH_INIT_NS = 100;
  localparam int FLASH_INIT_CYC = (FLASH_INIT_NS * 100 + 999) / 1000;

  // Power state machine, Gray coded
  typedef enum logic [2:0] {
    PS_RUN = 3'b000,
    PS_SLEEP = 3'b001,
    PS_DEEP = 3'b011,
    PS_DPD = 3'b010
  } pwr_state_t;

  // Protection level
  typedef enum logic [1:0] {
    PROT_NONE = 2'h0,
    PROT_ONE = 2'h1,
    PROT_TWO = 2'h2,
    PROT_THREE = 2'h3
  } prot_t;

  // Access grants derived from protection
  typedef struct packed {
    logic debug_en;
    logic boot_loader_en;
    logic boot_pin_en;
    logic sector0_wr_en;
    logic mass_erase_only;
  } access_t;

  // Register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

endpackage : pmu_pkg

// ===== verilog/power_mode_reset_wake_control.sv
`timescale 1ns/1ns
module power_mode_reset_wake_control
  import pmu_pkg::*;
#(
  parameter int START_PINS = 13,
  parameter int PERIPHS = 16,
  parameter int DIV_W = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Clock sources, already on mclk as enables
  input wire logic [3:0] clk_src_level,
  output logic clkout_level,
  output logic [1:0] main_clk_sel,
  output logic [DIV_W-1:0] core_div,
  // Core side
  input wire logic core_irq_pending,
  input wire logic core_sleep_req,
  output logic core_clk_en,
  output logic [PERIPHS-1:0] periph_clk_en,
  output logic [START_PINS-1:0] start_irq,
  // Analog and power
  output logic analog_on,
  output logic wdosc_on,
  output logic brown_on,
  output logic irc_on,
  output logic chip_power_on,
  // Pins from outside
  input wire logic [START_PINS-1:0] start_pin,
  input wire logic deep_wake_pin,
  input wire logic reset_pin_n,
  input wire logic wdog_reset,
  input wire logic brown_below_irq,
  input wire logic brown_below_rst,
  output logic [1:0] brown_irq_level,
  output logic [1:0] brown_rst_level,
  output logic brownout_irq,
  // Chip reset and flash
  output logic chip_resetn,
  output logic flash_init,
  output logic [31:0] core_fetch_addr,
  input wire logic [31:0] flash_prot_word,
  input wire logic flash_prot_valid,
  output logic debug_en,
  output logic boot_loader_en,
  output logic boot_pin_en,
  output logic sector0_wr_en,
  output logic mass_erase_only
);

  // Synchroniser stages for all pin inputs
  logic [START_PINS-1:0] start_s1_q, start_s2_q, start_prev_q;
  logic [4:0] misc_s1_q, misc_s2_q;
  logic wake_prev_q;

  // Two flops before any logic reads a pin
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      start_s1_q <= '0;
      start_s2_q <= '0;
      misc_s1_q <= 5'h01;
      misc_s2_q <= 5'h01;
    end else begin
      start_s1_q <= start_pin;
      start_s2_q <= start_s1_q;
      misc_s1_q <= {brown_below_rst, brown_below_irq, wdog_reset, deep_wake_pin, reset_pin_n};
      misc_s2_q <= misc_s1_q;
    end
  end

  logic pin_rstn_s, wake_s, wdog_s, bod_irq_s, bod_rst_s;
  assign pin_rstn_s = misc_s2_q[0];
  assign wake_s = misc_s2_q[1];
  assign wdog_s = misc_s2_q[2];
  assign bod_irq_s = misc_s2_q[3];
  assign bod_rst_s = misc_s2_q[4];

  // Software-visible registers
  logic [1:0] clkout_sel_q;
  logic [1:0] main_sel_q;
  logic [DIV_W-1:0] div_q;
  logic [PERIPHS-1:0] gate_q;
  logic [4:0] pwr_q;
  logic [START_PINS-1:0] start_en_q, start_flag_q;
  logic [3:0] brown_cfg_q;
  logic [3:0] rst_src_q;
  logic por_done_q;
  bus_req_t req;
  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // Power-down wake restarts the chip as a fresh power-up, back on RC
  pwr_state_t state_q;
  logic wake_rise, dpd_wake;
  assign wake_rise = wake_s & ~wake_prev_q;
  assign dpd_wake = state_q == PS_DPD && wake_rise;
  // Internal reset request from any source
  logic rst_req;
  assign rst_req = !pin_rstn_s || wdog_s || (bod_rst_s && brown_on);

  // Config registers; all return to defaults on any chip reset
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      clkout_sel_q <= CLKOUT_SEL_RST;
      main_sel_q <= MAIN_SEL_RST;
      div_q <= '0;
      gate_q <= PCLK_GATE_RST[PERIPHS-1:0];
      start_en_q <= START_EN_RST[START_PINS-1:0];
      brown_cfg_q <= BROWN_CFG_RST;
    end else if (rst_req || dpd_wake) begin
      // Soft reset puts clocking back on the RC oscillator
      clkout_sel_q <= CLKOUT_SEL_RST;
      main_sel_q <= MAIN_SEL_RST;
      div_q <= '0;
      gate_q <= PCLK_GATE_RST[PERIPHS-1:0];
      start_en_q <= START_EN_RST[START_PINS-1:0];
      brown_cfg_q <= BROWN_CFG_RST;
    end else if (req.wr) begin
      case (req.addr)
        OFF_CLKOUT_SEL: clkout_sel_q <= req.wdata[1:0];
        // Software must have the source stable first
        OFF_MAIN_SEL: begin
          main_sel_q <= req.wdata[1:0];
          div_q <= req.wdata[8 +: DIV_W];
        end
        OFF_PCLK_GATE: gate_q <= req.wdata[PERIPHS-1:0];
        OFF_START_EN: start_en_q <= req.wdata[START_PINS-1:0];
        OFF_BROWN_CFG: brown_cfg_q <= req.wdata[3:0];
        default: ;
      endcase
    end
  end

  // Power state machine
  logic [START_PINS-1:0] start_rise;
  assign start_rise = start_s2_q & ~start_prev_q;

  // Mode request from software or core sleep instruction
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_q <= PS_RUN;
      pwr_q <= '0;
    end else if (rst_req) begin
      state_q <= PS_RUN;
      pwr_q <= '0;
    end else begin
      if (req.wr && req.addr == OFF_PWR_CTRL) begin
        pwr_q <= req.wdata[4:0];
      end
      case (state_q)
        PS_RUN: begin
          if (core_sleep_req || (req.wr && req.addr == OFF_PWR_CTRL && req.wdata[PWR_SLEEP_BIT])) begin
            // Deepest requested mode wins
            if (pwr_q[PWR_DPD_BIT]) begin
              state_q <= PS_DPD;
            end else if (pwr_q[PWR_DEEP_BIT]) begin
              state_q <= PS_DEEP;
            end else begin
              state_q <= PS_SLEEP;
            end
          end
        end
        // Any interrupt resumes the core
        PS_SLEEP: if (core_irq_pending || |(start_rise & start_en_q)) state_q <= PS_RUN;
        // Only enabled start pins wake from deep-sleep
        PS_DEEP: if (|(start_rise & start_en_q)) state_q <= PS_RUN;
        // Only the dedicated wake pin, or a reset from the pin or watchdog, ends power-down
        PS_DPD: if (wake_rise) begin
          state_q <= PS_RUN;
          pwr_q <= '0;
        end
        default: state_q <= PS_RUN;
      endcase
    end
  end

  // Edge history and sticky start flags, set beats clear
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      start_prev_q <= '0;
      wake_prev_q <= 1'b0;
      start_flag_q <= '0;
    end else begin
      start_prev_q <= start_s2_q;
      wake_prev_q <= wake_s;
      if (req.wr && req.addr == OFF_START_FLAG) begin
        start_flag_q <= (start_flag_q & ~req.wdata[START_PINS-1:0]) | (start_rise & start_en_q);
      end else begin
        start_flag_q <= start_flag_q | (start_rise & start_en_q);
      end
    end
  end

  // Reset source capture and flash init sequencing
  logic [7:0] init_cnt_q;
  prot_t prot_q;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rst_src_q <= 4'h1;
      por_done_q <= 1'b0;
      init_cnt_q <= '0;
      prot_q <= PROT_NONE;
    end else if (rst_req || dpd_wake) begin
      rst_src_q <= dpd_wake ? 4'h1 : {bod_rst_s && brown_on, wdog_s, !pin_rstn_s, 1'b0};
      por_done_q <= 1'b0;
      init_cnt_q <= '0;
    end else if (!por_done_q) begin
      if (init_cnt_q < 8'(FLASH_INIT_CYC)) begin
        init_cnt_q <= init_cnt_q + 8'h01;
      end else if (flash_prot_valid) begin
        // Decode protection before releasing debug or loader
        case (flash_prot_word)
          PAT_LEVEL1: prot_q <= PROT_ONE;
          PAT_LEVEL2: prot_q <= PROT_TWO;
          PAT_LEVEL3: prot_q <= PROT_THREE;
          default: prot_q <= PROT_NONE;
        endcase
        por_done_q <= 1'b1;
      end
    end
  end

  // Protection to access grants
  access_t acc;
  always_comb begin
    acc = '{debug_en: 1'b0, boot_loader_en: 1'b0, boot_pin_en: 1'b0, sector0_wr_en: 1'b0, mass_erase_only: 1'b0};
    if (por_done_q) begin
      case (prot_q)
        PROT_NONE: acc = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
        PROT_ONE: acc = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
        PROT_TWO: acc = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
        PROT_THREE: acc = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
        default: acc = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
      endcase
    end
  end

  // Output flops: clocks, power and grants
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      clkout_level <= 1'b0;
      main_clk_sel <= SRC_IRC;
      core_div <= '0;
      core_clk_en <= 1'b0;
      periph_clk_en <= '0;
      start_irq <= '0;
      analog_on <= 1'b1;
      wdosc_on <= 1'b1;
      brown_on <= 1'b1;
      irc_on <= 1'b1;
      chip_power_on <= 1'b1;
      brown_irq_level <= 2'h0;
      brown_rst_level <= 2'h0;
      brownout_irq <= 1'b0;
      chip_resetn <= 1'b0;
      flash_init <= 1'b1;
      core_fetch_addr <= '0;
      debug_en <= 1'b0;
      boot_loader_en <= 1'b0;
      boot_pin_en <= 1'b0;
      sector0_wr_en <= 1'b0;
      mass_erase_only <= 1'b0;
    end else begin
      clkout_level <= clk_src_level[clkout_sel_q];
      main_clk_sel <= main_sel_q;
      core_div <= div_q;
      core_clk_en <= por_done_q && state_q == PS_RUN;
      // Peripherals run in sleep; stop in deeper modes
      periph_clk_en <= (state_q == PS_RUN || state_q == PS_SLEEP) ? gate_q : '0;
      start_irq <= start_rise & start_en_q;
      analog_on <= state_q == PS_RUN || state_q == PS_SLEEP;
      wdosc_on <= state_q != PS_DPD && (state_q != PS_DEEP || pwr_q[PWR_KEEP_WDOSC_BIT]);
      brown_on <= state_q != PS_DPD && (state_q != PS_DEEP || pwr_q[PWR_KEEP_BROWN_BIT]);
      irc_on <= (state_q == PS_RUN || state_q == PS_SLEEP) || rst_req;
      chip_power_on <= state_q != PS_DPD;
      brown_irq_level <= brown_cfg_q[1:0];
      brown_rst_level <= brown_cfg_q[3:2];
      brownout_irq <= bod_irq_s && brown_on;
      chip_resetn <= por_done_q && !rst_req;
      flash_init <= !por_done_q;
      core_fetch_addr <= '0;
      debug_en <= acc.debug_en;
      boot_loader_en <= acc.boot_loader_en;
      boot_pin_en <= acc.boot_pin_en;
      sector0_wr_en <= acc.sector0_wr_en;
      mass_erase_only <= acc.mass_erase_only;
    end
  end

  // Read port, data one cycle after strobe
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= '0;
    end else if (req.rd) begin
      case (req.addr)
        OFF_CLKOUT_SEL: reg_rdata <= 32'(clkout_sel_q);
        OFF_MAIN_SEL: reg_rdata <= 32'({div_q, 6'h00, main_sel_q});
        OFF_PCLK_GATE: reg_rdata <= 32'(gate_q);
        OFF_PWR_CTRL: reg_rdata <= 32'({state_q, 3'h0, pwr_q});
        OFF_START_EN: reg_rdata <= 32'(start_en_q);
        OFF_START_FLAG: reg_rdata <= 32'(start_flag_q);
        OFF_BROWN_CFG: reg_rdata <= 32'(brown_cfg_q);
        OFF_STATUS: reg_rdata <= 32'({prot_q, por_done_q, bod_irq_s});
        OFF_RESET_SRC: reg_rdata <= 32'(rst_src_q);
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  // Level three must close the debug port
  property p_prot3_no_debug;
    @(posedge mclk) disable iff (!resetn)
    (prot_q == PROT_THREE && por_done_q) |=> !debug_en && !boot_pin_en;
  endproperty
  a_prot3_no_debug: assert property (p_prot3_no_debug) else $error("debug open at level three");

  // Level one keeps sector 0 closed
  property p_prot1;
    @(posedge mclk) disable iff (!resetn)
    (prot_q == PROT_ONE && por_done_q) |=> !debug_en && boot_loader_en && !sector0_wr_en;
  endproperty
  a_prot1: assert property (p_prot1) else $error("level one grants wrong");

  // Level two allows only mass erase
  property p_prot2;
    @(posedge mclk) disable iff (!resetn)
    (prot_q == PROT_TWO && por_done_q) |=> !debug_en && mass_erase_only;
  endproperty
  a_prot2: assert property (p_prot2) else $error("level two grants wrong");

  // Sleep holds the core clock off
  property p_sleep_clk;
    @(posedge mclk) disable iff (!resetn)
    (state_q == PS_SLEEP) |=> !core_clk_en;
  endproperty
  a_sleep_clk: assert property (p_sleep_clk) else $error("core clock in sleep");

  // Deep-sleep powers analog down
  property p_deep_analog;
    @(posedge mclk) disable iff (!resetn)
    (state_q == PS_DEEP) |=> !analog_on;
  endproperty
  a_deep_analog: assert property (p_deep_analog) else $error("analog on in deep-sleep");

  // Enabled start edge in deep-sleep wakes next cycle
  property p_start_wake;
    @(posedge mclk) disable iff (!resetn)
    (state_q == PS_DEEP && |(start_rise & start_en_q) && !rst_req) |=> state_q == PS_RUN;
  endproperty
  a_start_wake: assert property (p_start_wake) else $error("start pin did not wake");

  // Any reset source pulls chip reset
  property p_reset_merge;
    @(posedge mclk) disable iff (!resetn)
    rst_req |=> !chip_resetn ##1 !chip_resetn;
  endproperty
  a_reset_merge: assert property (p_reset_merge) else $error("reset source ignored");

  // Power-down leaves power off until wake pin
  property p_dpd_power;
    @(posedge mclk) disable iff (!resetn)
    (state_q == PS_DPD && !wake_rise && !rst_req) |=> state_q == PS_DPD ##1 !chip_power_on;
  endproperty
  a_dpd_power: assert property (p_dpd_power) else $error("power-down left early");

  // Reset returns main clock to RC
  property p_rc_after_reset;
    @(posedge mclk) disable iff (!resetn)
    rst_req |=> ##1 main_clk_sel == SRC_IRC;
  endproperty
  a_rc_after_reset: assert property (p_rc_after_reset) else $error("not on RC after reset");

endmodule : power_mode_reset_wake_control

// ===== tb/pmu_far_side.sv
`timescale 1ns/1ns
module pmu_far_side
  import pmu_pkg::*;
#(
  parameter int FLASH_LAT = 3
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // From the block
  input wire logic flash_init,
  input wire logic [12:0] start_irq,
  input wire logic core_clk_en,
  // From the bench
  input wire logic [31:0] prot_pat,
  // To the block
  output logic [31:0] flash_prot_word,
  output logic flash_prot_valid,
  output logic [3:0] clk_src_level,
  output logic core_irq_pending
);
  logic [3:0] lat_q; // Flash read latency count
  logic init_q; // Last flash_init
  logic [7:0] tick_q; // Free-running source phases

  // Flash answers a few cycles after each init starts
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      init_q <= 1'b0;
      lat_q <= 4'h0;
    end else begin
      init_q <= flash_init;
      if (flash_init && !init_q) begin
        lat_q <= 4'h0;
      end else if (flash_init && lat_q != 4'(FLASH_LAT)) begin
        lat_q <= lat_q + 4'h1;
      end
    end
  end
  assign flash_prot_valid = (lat_q == 4'(FLASH_LAT));
  // Garbage that changes every cycle until valid, so a stale word is never read
  assign flash_prot_word = flash_prot_valid ? prot_pat : ~prot_pat ^ {4{tick_q}};

  // Sources toggle at different rates, so a wrong select shows
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      tick_q <= 8'h00;
    end else begin
      tick_q <= tick_q + 8'h01;
    end
  end
  assign clk_src_level = {tick_q[0], tick_q[3], tick_q[2], tick_q[1]};

  // Irq controller: a start pin irq stays pending until the core runs
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      core_irq_pending <= 1'b0;
    end else if (|start_irq) begin
      core_irq_pending <= 1'b1;
    end else if (core_clk_en) begin
      core_irq_pending <= 1'b0;
    end
  end
endmodule : pmu_far_side

// ===== tb/test_power_mode_reset_wake_control.sv
`timescale 1ns/1ns
module test_power_mode_reset_wake_control
  import pmu_pkg::*;
;
  // Clock, reset and register port
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  // Core side and clocks
  logic [3:0] clk_src_level, src_prev;
  logic clkout_level, core_irq_pending, core_clk_en;
  logic core_sleep_req = 1'b0;
  logic [1:0] main_clk_sel, brown_irq_level, brown_rst_level;
  logic [7:0] core_div;
  logic [15:0] periph_clk_en;
  logic [12:0] start_irq, seen_irq;
  logic analog_on, wdosc_on, brown_on, irc_on, chip_power_on, brownout_irq;
  // Pins driven by the bench
  logic [12:0] start_pin = 13'h0;
  logic deep_wake_pin = 1'b0;
  logic reset_pin_n = 1'b1;
  logic wdog_reset = 1'b0;
  logic brown_below_irq = 1'b0;
  logic brown_below_rst = 1'b0;
  // Reset, flash and grants
  logic chip_resetn, flash_init, flash_prot_valid;
  logic [31:0] core_fetch_addr, flash_prot_word, d;
  logic [31:0] prot_pat = 32'h0;
  logic debug_en, boot_loader_en, boot_pin_en, sector0_wr_en, mass_erase_only;
  int n_fail = 0;
  int checked = 0;
  int i, k;
  // Register rows: address, reset value, write data, read back
  logic [7:0] ra[6] = '{OFF_CLKOUT_SEL, OFF_MAIN_SEL, OFF_PCLK_GATE, OFF_START_EN, OFF_BROWN_CFG, 8'h44};
  logic [31:0] rr[6] = '{32'h0, 32'h0, 32'hffff, 32'h0, 32'h0, 32'h0};
  logic [31:0] rw[6] = '{32'h2, 32'h501, 32'hf0f, 32'h1fff, 32'he, 32'hffffffff};
  logic [31:0] rx[6] = '{32'h2, 32'h501, 32'hf0f, 32'h1fff, 32'he, 32'h0};
  // Protection rows: pattern, grants {debug, loader, pin, sector0, erase}, mask
  logic [31:0] pat[4] = '{32'h0, PAT_LEVEL1, PAT_LEVEL2, PAT_LEVEL3};
  logic [4:0] pexp[4] = '{5'b11110, 5'b01100, 5'b01101, 5'b00000};
  logic [4:0] pmsk[4] = '{5'b11111, 5'b11111, 5'b11101, 5'b11100};

  power_mode_reset_wake_control DUT (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .clk_src_level(clk_src_level),
    .clkout_level(clkout_level), .main_clk_sel(main_clk_sel), .core_div(core_div),
    .core_irq_pending(core_irq_pending), .core_sleep_req(core_sleep_req), .core_clk_en(core_clk_en),
    .periph_clk_en(periph_clk_en), .start_irq(start_irq), .analog_on(analog_on), .wdosc_on(wdosc_on),
    .brown_on(brown_on), .irc_on(irc_on), .chip_power_on(chip_power_on), .start_pin(start_pin),
    .deep_wake_pin(deep_wake_pin), .reset_pin_n(reset_pin_n), .wdog_reset(wdog_reset),
    .brown_below_irq(brown_below_irq), .brown_below_rst(brown_below_rst), .brown_irq_level(brown_irq_level),
    .brown_rst_level(brown_rst_level), .brownout_irq(brownout_irq), .chip_resetn(chip_resetn),
    .flash_init(flash_init), .core_fetch_addr(core_fetch_addr), .flash_prot_word(flash_prot_word),
    .flash_prot_valid(flash_prot_valid), .debug_en(debug_en), .boot_loader_en(boot_loader_en),
    .boot_pin_en(boot_pin_en), .sector0_wr_en(sector0_wr_en), .mass_erase_only(mass_erase_only));

  pmu_far_side far (.mclk(mclk), .resetn(resetn), .flash_init(flash_init), .start_irq(start_irq),
    .core_clk_en(core_clk_en), .prot_pat(prot_pat), .flash_prot_word(flash_prot_word),
    .flash_prot_valid(flash_prot_valid), .clk_src_level(clk_src_level), .core_irq_pending(core_irq_pending));

  // 100 MHz clock
  always #5 mclk = ~mclk;

  // Source levels as the block saw them, and every start irq pulse
  always @(posedge mclk) begin
    src_prev <= clk_src_level;
    seen_irq <= (resetn ? seen_irq : 13'h0) | start_irq;
  end

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One-cycle write strobe
  task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : reg_write

  // Read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    v = reg_rdata;
  endtask : reg_read

  // Verdict and end of run
  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict

  // Hang guard, well past the few hundred cycles the run needs
  initial begin
    #200000;
    n_fail++;
    give_verdict();
  end

  initial begin
    // Held reset: chip in reset, flash initialising, nothing granted
    repeat (19) @(posedge mclk);
    @(negedge mclk);
    check(chip_resetn, 1'b0);
    check({flash_init, irc_on}, 2'b11);
    check({debug_en, boot_loader_en}, 2'h0);
    check(reg_rdata, 32'h0);
    @(posedge mclk);
    resetn <= 1'b1;
    for (k = 0; k < 60 && chip_resetn !== 1'b1; k++) @(negedge mclk);
    check(core_fetch_addr, 32'h0);
    check(main_clk_sel, SRC_IRC);
    // Register table: reset value, write, read back; last row unmapped
    for (i = 0; i < 6; i++) begin
      reg_read(ra[i], d);
      check(d, rr[i]);
      reg_write(ra[i], rw[i]);
      reg_read(ra[i], d);
      check(d, rx[i]);
    end
    check({main_clk_sel, core_div}, 10'h105);
    check({periph_clk_en, brown_irq_level, brown_rst_level}, 20'hf0f_b);
    // Clock output follows each source
    for (i = 0; i < 4; i++) begin
      reg_write(OFF_CLKOUT_SEL, i);
      repeat (3) @(negedge mclk);
      repeat (4) begin
        @(negedge mclk);
        check(clkout_level, src_prev[i]);
      end
    end
    // Brownout warning, then its status bit with the irq unused
    @(posedge mclk);
    brown_below_irq <= 1'b1;
    for (k = 0; k < 8 && brownout_irq !== 1'b1; k++) @(negedge mclk);
    check(brownout_irq, 1'b1);
    reg_read(OFF_STATUS, d);
    check(d[0], 1'b1);
    @(posedge mclk);
    brown_below_irq <= 1'b0;
    for (k = 0; k < 8 && brownout_irq !== 1'b0; k++) @(negedge mclk);
    check(brownout_irq, 1'b0);
    // Sleep: core stops, gated peripherals run on, start pin 3 wakes
    @(posedge mclk);
    core_sleep_req <= 1'b1;
    @(posedge mclk);
    core_sleep_req <= 1'b0;
    for (k = 0; k < 8 && core_clk_en !== 1'b0; k++) @(negedge mclk);
    check({core_clk_en, periph_clk_en}, 17'h00f0f);
    @(posedge mclk);
    start_pin[3] <= 1'b1;
    for (k = 0; k < 20 && core_clk_en !== 1'b1; k++) @(negedge mclk);
    check({core_clk_en, seen_irq[3]}, 2'b11);
    // Deep-sleep on RC with wdosc kept; top start pin wakes
    reg_write(OFF_MAIN_SEL, 32'h500);
    reg_write(OFF_PWR_CTRL, 32'h0a);
    reg_write(OFF_PWR_CTRL, 32'h0b);
    for (k = 0; k < 8 && core_clk_en !== 1'b0; k++) @(negedge mclk);
    repeat (2) @(negedge mclk);
    check({core_clk_en, analog_on, wdosc_on, brown_on, periph_clk_en}, 20'h20000);
    @(posedge mclk);
    start_pin[12] <= 1'b1;
    for (k = 0; k < 30 && core_clk_en !== 1'b1; k++) @(negedge mclk);
    check({core_clk_en, analog_on, seen_irq[12]}, 3'b111);
    // Sticky flags of both wakes, then write-one-clear of pin 3
    reg_read(OFF_START_FLAG, d);
    check(d, 32'h1008);
    reg_write(OFF_START_FLAG, 32'h8);
    reg_read(OFF_START_FLAG, d);
    check(d, 32'h1000);
    @(posedge mclk);
    start_pin <= 13'h0;
    // Each reset source in turn, each protection pattern decoded afresh
    for (i = 0; i < 4; i++) begin
      @(posedge mclk);
      prot_pat <= pat[i];
      reset_pin_n <= (i % 3 != 0);
      wdog_reset <= (i % 3 == 1);
      brown_below_rst <= (i % 3 == 2);
      repeat (5) @(negedge mclk);
      check({chip_resetn, flash_init, irc_on}, 3'b011);
      @(posedge mclk);
      reset_pin_n <= 1'b1;
      wdog_reset <= 1'b0;
      brown_below_rst <= 1'b0;
      for (k = 0; k < 60 && chip_resetn !== 1'b1; k++) @(negedge mclk);
      check({chip_resetn, flash_init, main_clk_sel}, {2'b10, MAIN_SEL_RST});
      check({debug_en, boot_loader_en, boot_pin_en, sector0_wr_en, mass_erase_only} & pmsk[i], pexp[i]);
      reg_read(OFF_RESET_SRC, d);
      check(d[(i % 3) + 1], 1'b1);
    end
    // Deep power-down: start pins ignored, only the wake pin restarts on RC
    @(posedge mclk);
    prot_pat <= 32'h0;
    reg_write(OFF_START_EN, 32'h1fff);
    reg_write(OFF_MAIN_SEL, 32'h1);
    reg_write(OFF_PWR_CTRL, 32'h4);
    reg_write(OFF_PWR_CTRL, 32'h5);
    for (k = 0; k < 10 && chip_power_on !== 1'b0; k++) @(negedge mclk);
    check(chip_power_on, 1'b0);
    @(posedge mclk);
    start_pin[0] <= 1'b1;
    repeat (10) @(negedge mclk);
    check(chip_power_on, 1'b0);
    @(posedge mclk);
    deep_wake_pin <= 1'b1;
    for (k = 0; k < 40 && chip_power_on !== 1'b1; k++) @(negedge mclk);
    for (k = 0; k < 60 && chip_resetn !== 1'b1; k++) @(negedge mclk);
    check({chip_power_on, chip_resetn, irc_on, main_clk_sel}, {3'b111, SRC_IRC});
    give_verdict();
  end
endmodule : test_power_mode_reset_wake_control
